/* File: rtl/spi_master_transfer_engine.sv */
// serial master transfer engine: baud generator, holding regs, shifter
`timescale 1ns/1ns
`default_nettype none
module spi_master_transfer_engine
  import spi_xfer_pkg::*;
#(
  parameter int WORD_W = spi_xfer_pkg::WORD_BITS
) (
  input  wire logic                                clk_i,
  input  wire logic                                reset_n_i,
  input  wire logic                                enable_i,
  input  wire logic [spi_xfer_pkg::DIV_BITS-1:0]   baud_div_i,
  input  wire logic [spi_xfer_pkg::NUM_SLAVES-1:0] polarity_i,
  input  wire logic [spi_xfer_pkg::NUM_SLAVES-1:0] clock_phase_select_i,
  input  wire logic [spi_xfer_pkg::DLY_BITS-1:0]   inter_transfer_delay_i,
  input  wire logic                                tx_write_i,
  input  wire logic [WORD_W-1:0]                   tx_data_i,
  input  wire logic [spi_xfer_pkg::SEL_BITS-1:0]   slave_select_field_i,
  input  wire logic                                rx_read_i,
  input  wire logic                                overrun_clear_i,
  input  wire logic                                miso_i,
  output logic                                     mosi_o,
  output logic                                     serial_clock_line_o,
  output logic      [spi_xfer_pkg::SEL_BITS-1:0]   chip_select_n_o,
  output logic      [WORD_W-1:0]                   rx_hold_reg_o,
  output logic      [spi_xfer_pkg::SEL_BITS-1:0]   rx_tag_o,
  output logic                                     tx_hold_empty_flag_o,
  output logic                                     tx_dma_req_o,
  output logic                                     transmission_complete_flag_o,
  output logic                                     rx_full_flag_o,
  output logic                                     overrun_error_flag_o
);
  localparam int CNT_W = $clog2(WORD_W) + 1;
  localparam int QW    = WORD_W + SEL_BITS;
  localparam int DLYC  = DLY_BITS + $clog2(DLY_UNIT_CYCLES);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  xfer_state_e          state_reg;
  logic [WORD_W-1:0]    tx_hold_reg;
  logic [SEL_BITS-1:0]  tx_sel_reg;
  logic                 hold_full_reg;
  logic [WORD_W-1:0]    shift_reg;
  logic [SEL_BITS-1:0]  cur_sel_reg;
  logic [CNT_W-1:0]     bit_cnt_reg;
  logic [DIV_BITS-1:0]  baud_cnt_reg;
  logic                 sclk_reg;
  logic                 edge_half_reg;
  logic [DLYC-1:0]      delay_cnt_reg;
  logic                 complete_reg;
  logic                 overrun_reg;
  logic                 miso_sample_reg;
  logic                 q_not_empty;
  logic                 q_full;
  logic [QW-1:0]        q_head;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [1:0] sel_idx = cur_sel_reg[1:0];
  wire       cpol    = polarity_i[sel_idx];
  wire       cpha_n  = clock_phase_select_i[sel_idx];
  wire       baud_tick = (baud_cnt_reg == '0);
  wire       leading = baud_tick && !edge_half_reg;
  wire       trailing = baud_tick && edge_half_reg;
  // sample on leading edge when phase select high, else trailing
  wire       sample_edge = cpha_n ? leading : trailing;
  wire       change_edge = cpha_n ? trailing : leading;
  wire       last_bit  = (bit_cnt_reg == CNT_W'(WORD_W - 1));
  wire       word_done = (state_reg == ST_SHIFT) && trailing && last_bit;
  wire       have_next = hold_full_reg || tx_write_i;
  wire       start_idle = enable_i && (state_reg == ST_IDLE) && have_next;
  wire       reload = word_done && have_next;
  wire       load_shift = start_idle || reload;
  wire [WORD_W-1:0]   next_word = hold_full_reg ? tx_hold_reg : tx_data_i;
  wire [SEL_BITS-1:0] next_sel  = hold_full_reg ? tx_sel_reg : slave_select_field_i;
  // trailing-edge sampling takes the live input, leading-edge uses the held sample
  wire       rx_bit    = cpha_n ? miso_sample_reg : miso_i;
  wire [WORD_W-1:0]   rx_word   = {shift_reg[WORD_W-2:0], rx_bit};
  // a write clears the empty flag even when the word goes straight to the shifter
  wire       hold_empty = !hold_full_reg && !tx_write_i;
  wire       delay_en  = (inter_transfer_delay_i != '0);
  wire       delay_end = (state_reg == ST_DELAY) && (delay_cnt_reg == '0);
  wire [DLYC-1:0] delay_load = DLYC'(inter_transfer_delay_i) * DLYC'(DLY_UNIT_CYCLES);

  // ---------------------------------------------------------------
  // receive queue
  // ---------------------------------------------------------------
  spi_rx_queue #(
    .WIDTH (QW),
    .DEPTH (RXQ_DEPTH),
    .PTR_W (RXQ_PTR_BITS)
  ) u_rxq (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .push_i      (word_done),
    .push_data_i ({cur_sel_reg, rx_word}),
    .pop_i       (rx_read_i),
    .head_data_o (q_head),
    .not_empty_o (q_not_empty),
    .full_o      (q_full)
  );

  // ---------------------------------------------------------------
  // transmit holding register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_hold_reg   <= '0;
      tx_sel_reg    <= SEL_IDLE;
      hold_full_reg <= 1'b0;
    end else if (tx_write_i && !(load_shift && !hold_full_reg)) begin
      tx_hold_reg   <= tx_data_i;
      tx_sel_reg    <= slave_select_field_i;
      hold_full_reg <= 1'b1;
    end else if (load_shift) begin
      hold_full_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // baud generator and serial clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      baud_cnt_reg  <= DIV_RESET;
      edge_half_reg <= 1'b0;
      sclk_reg      <= 1'b0;
    end else if (state_reg != ST_SHIFT || load_shift) begin
      baud_cnt_reg  <= baud_div_i;
      edge_half_reg <= 1'b0;
      sclk_reg      <= load_shift ? polarity_i[next_sel[1:0]] : cpol;
    end else if (baud_tick) begin
      baud_cnt_reg  <= baud_div_i;
      edge_half_reg <= !edge_half_reg;
      sclk_reg      <= !sclk_reg;
    end else begin
      baud_cnt_reg  <= baud_cnt_reg - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // shifter and sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg       <= ST_IDLE;
      shift_reg       <= '0;
      cur_sel_reg     <= SEL_IDLE;
      bit_cnt_reg     <= '0;
      delay_cnt_reg   <= '0;
      miso_sample_reg <= 1'b0;
    end else begin
      if (sample_edge && state_reg == ST_SHIFT) begin
        miso_sample_reg <= miso_i;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start_idle) begin
            shift_reg   <= next_word;
            cur_sel_reg <= next_sel;
            bit_cnt_reg <= '0;
            state_reg   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (reload) begin
            shift_reg   <= next_word;
            cur_sel_reg <= next_sel;
            bit_cnt_reg <= '0;
          end else if (word_done) begin
            delay_cnt_reg <= delay_load;
            state_reg     <= delay_en ? ST_DELAY : ST_IDLE;
          end else if (trailing) begin
            shift_reg   <= {shift_reg[WORD_W-2:0], rx_bit};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (change_edge) begin
            shift_reg   <= shift_reg;
          end
        end
        ST_DELAY: begin
          if (delay_end) begin
            state_reg <= ST_IDLE;
          end else begin
            delay_cnt_reg <= delay_cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status flags and registered outputs
  // ---------------------------------------------------------------
  wire now_idle = (state_reg == ST_IDLE && !start_idle) ||
                  (word_done && !have_next && !delay_en) || delay_end;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      complete_reg <= 1'b1;
      overrun_reg  <= 1'b0;
    end else begin
      complete_reg <= now_idle && !hold_full_reg && !tx_write_i;
      if (word_done && q_full && !rx_read_i) begin
        overrun_reg <= 1'b1;
      end else if (overrun_clear_i) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mosi_o                       <= 1'b0;
      serial_clock_line_o          <= 1'b0;
      chip_select_n_o              <= SEL_IDLE;
      rx_hold_reg_o                <= '0;
      rx_tag_o                     <= '0;
      tx_hold_empty_flag_o         <= 1'b1;
      tx_dma_req_o                 <= 1'b1;
      transmission_complete_flag_o <= 1'b1;
      rx_full_flag_o               <= 1'b0;
      overrun_error_flag_o         <= 1'b0;
    end else begin
      mosi_o                       <= shift_reg[WORD_W-1];
      serial_clock_line_o          <= sclk_reg;
      chip_select_n_o              <= (state_reg == ST_SHIFT) ? cur_sel_reg : SEL_IDLE;
      rx_hold_reg_o                <= q_head[WORD_W-1:0];
      rx_tag_o                     <= q_head[QW-1:WORD_W];
      tx_hold_empty_flag_o         <= hold_empty;
      tx_dma_req_o                 <= hold_empty;
      transmission_complete_flag_o <= complete_reg;
      rx_full_flag_o               <= q_not_empty;
      overrun_error_flag_o         <= overrun_reg;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/spi_rx_queue.sv */
// four-entry receive queue holding received word and slave tag
`timescale 1ns/1ns
`default_nettype none
module spi_rx_queue #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4,
  parameter int PTR_W = 2
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_data_o,
  output logic                  not_empty_o,
  output logic                  full_o
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0]   count_reg;
  wire              do_pop  = pop_i && (count_reg != '0);
  wire              do_push = push_i && (count_reg != (PTR_W+1)'(DEPTH) || do_pop);
  wire  [PTR_W-1:0] rd_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      head_data_o <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      rd_ptr_reg <= rd_next;
      count_reg  <= count_reg + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
      // registered head: bypass when queue runs empty and a push arrives
      if (do_push && (count_reg == (PTR_W+1)'(do_pop)) ) begin
        head_data_o <= push_data_i;
      end else begin
        head_data_o <= mem_reg[rd_next];
      end
    end
  end

  assign not_empty_o = (count_reg != '0);
  assign full_o      = (count_reg == (PTR_W+1)'(DEPTH));
endmodule
`default_nettype wire

/* File: rtl/spi_xfer_pkg.sv */
// constants for the serial master transfer engine
package spi_xfer_pkg;
  localparam int WORD_BITS      = 8;
  localparam int SEL_BITS       = 4;
  localparam int DIV_BITS       = 8;
  localparam int DLY_BITS       = 8;
  localparam int RXQ_DEPTH      = 4;
  localparam int RXQ_PTR_BITS   = 2;
  localparam int NUM_SLAVES     = 4;
  localparam logic [SEL_BITS-1:0] SEL_IDLE = 4'hF;
  localparam logic [DIV_BITS-1:0] DIV_RESET = 8'h01;
  localparam logic [DLY_BITS-1:0] DLY_RESET = 8'h00;
  localparam int DLY_UNIT_CYCLES = 32;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DELAY = 2'b10
  } xfer_state_e;
endpackage

/* File: test/spi_master_transfer_engine_monitor.sv */
// port-level assertions for the transfer engine
`timescale 1ns/1ns
`default_nettype none
module spi_master_transfer_engine_monitor #(
  parameter int WORD_W = 8
) (
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire logic              enable_i,
  input wire logic [7:0]        baud_div_i,
  input wire logic              tx_write_i,
  input wire logic [3:0]        slave_select_field_i,
  input wire logic              rx_read_i,
  input wire logic              overrun_clear_i,
  input wire logic              serial_clock_line_o,
  input wire logic [3:0]        chip_select_n_o,
  input wire logic              tx_hold_empty_flag_o,
  input wire logic              tx_dma_req_o,
  input wire logic              transmission_complete_flag_o,
  input wire logic              rx_full_flag_o,
  input wire logic              overrun_error_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence start_s;
    tx_write_i && enable_i && transmission_complete_flag_o;
  endsequence
  dma_tracks_a: assert property (tx_dma_req_o == tx_hold_empty_flag_o)
    else $error("dma request differs from hold-empty flag");
  empty_clear_a: assert property (tx_write_i |=> !tx_hold_empty_flag_o)
    else $error("hold-empty flag not cleared by write");
  start_cs_a: assert property (start_s |-> ##2 chip_select_n_o == $past(slave_select_field_i, 2))
    else $error("idle write did not start transfer");
  busy_after_a: assert property (start_s |-> ##[1:2] !transmission_complete_flag_o)
    else $error("complete flag stayed high after write");
  idle_cs_a: assert property (transmission_complete_flag_o |-> chip_select_n_o == 4'hF)
    else $error("chip select active while complete");
  sclk_quiet_a: assert property (
      transmission_complete_flag_o && $past(transmission_complete_flag_o)
      |-> $stable(serial_clock_line_o))
    else $error("serial clock moved while idle");
  // flag output lags the clear input by two registers
  overrun_hold_a: assert property (
      overrun_error_flag_o && !$past(overrun_clear_i) |=> overrun_error_flag_o)
    else $error("overrun flag dropped without clear");
  // flag output lags the pop by two register stages
  rxfull_hold_a: assert property (
      rx_full_flag_o && !$past(rx_read_i) |=> rx_full_flag_o)
    else $error("receive-full dropped without read");
  half_period_a: assert property (
      baud_div_i != 8'h00 && $changed(serial_clock_line_o)
      |=> $stable(serial_clock_line_o))
    else $error("serial clock half period too short");
endmodule
bind spi_master_transfer_engine spi_master_transfer_engine_monitor #(.WORD_W(WORD_W)) mon (
  .clk_i                        (clk_i),
  .reset_n_i                    (reset_n_i),
  .enable_i                     (enable_i),
  .baud_div_i                   (baud_div_i),
  .tx_write_i                   (tx_write_i),
  .slave_select_field_i         (slave_select_field_i),
  .rx_read_i                    (rx_read_i),
  .overrun_clear_i              (overrun_clear_i),
  .serial_clock_line_o          (serial_clock_line_o),
  .chip_select_n_o              (chip_select_n_o),
  .tx_hold_empty_flag_o         (tx_hold_empty_flag_o),
  .tx_dma_req_o                 (tx_dma_req_o),
  .transmission_complete_flag_o (transmission_complete_flag_o),
  .rx_full_flag_o               (rx_full_flag_o),
  .overrun_error_flag_o         (overrun_error_flag_o)
);
`default_nettype wire

/* File: test/spi_master_transfer_engine_test.sv */
// self-checking bench for the transfer engine
`timescale 1ns/1ns
`default_nettype none
module spi_master_transfer_engine_test;
  import spi_xfer_pkg::*;
  logic clk_i, reset_n_i, enable_i, tx_write_i, rx_read_i, overrun_clear_i, miso, mosi, sclk;
  logic [7:0] baud_div_i, tx_data_i, dly, rx_data, got, reply;
  logic [3:0] pol, pha, sel, cs_n, rx_tag;
  logic empty, dma, done, rx_full, ovr;
  int num_errors, num_checks, cyc, n;
  spi_master_transfer_engine DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
    .baud_div_i(baud_div_i), .polarity_i(pol), .clock_phase_select_i(pha),
    .inter_transfer_delay_i(dly), .tx_write_i(tx_write_i), .tx_data_i(tx_data_i),
    .slave_select_field_i(sel), .rx_read_i(rx_read_i), .overrun_clear_i(overrun_clear_i),
    .miso_i(miso), .mosi_o(mosi), .serial_clock_line_o(sclk), .chip_select_n_o(cs_n),
    .rx_hold_reg_o(rx_data), .rx_tag_o(rx_tag), .tx_hold_empty_flag_o(empty),
    .tx_dma_req_o(dma), .transmission_complete_flag_o(done), .rx_full_flag_o(rx_full),
    .overrun_error_flag_o(ovr));
  spi_slave_model slave (.sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .reply_i(reply),
    .miso_o(miso), .got_o(got));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic write_word(input logic [7:0] d, input logic [3:0] s);
    tx_data_i = d;
    sel = s;
    tx_write_i = 1'b1;
    tick(1);
    tx_write_i = 1'b0;
  endtask
  // waits for the complete flag to drop, then to rise again when the transfer ends
  task automatic wait_done(output int cnt);
    cnt = 0;
    while (done !== 1'b0 && cnt < 10) begin tick(1); cnt++; end
    while (done !== 1'b1 && cnt < 3000) begin tick(1); cnt++; end
    check("done flag", done, 1'b1);
  endtask
  task automatic read_word(input logic [7:0] d, input logic [3:0] t);
    check("rx word", rx_data, d);
    check("rx tag", rx_tag, t);
    rx_read_i = 1'b1;
    tick(1);
    rx_read_i = 1'b0;
    tick(2);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    {reset_n_i, tx_write_i, rx_read_i, overrun_clear_i, pol, dly} = '0;
    {tx_data_i, sel, cyc, num_errors, num_checks} = '0;
    enable_i = 1'b1;
    baud_div_i = 8'h01;
    pha = 4'hF;
    reply = 8'h3C;
    tick(6);
    reset_n_i = 1'b1;
    check("reset flags", {empty, dma, done, rx_full, ovr, cs_n}, 16'h01CF);
    $display("test reset done");
    write_word(8'hA5, 4'hE);
    wait_done(n);
    check("slave got", got, 8'hA5);
    check("rx full", rx_full, 1'b1);
    read_word(8'h3C, 4'hE);
    check("rx empty", rx_full, 1'b0);
    $display("test single done");
    write_word(8'h81, 4'hD);
    tick(3);
    write_word(8'h42, 4'hB);
    check("hold held", {empty, dma}, 2'b00);
    wait_done(n);
    check("second word", got, 8'h42);
    read_word(8'h3C, 4'hD);
    read_word(8'h3C, 4'hB);
    $display("test back-to-back done");
    for (int i = 0; i < 5; i++) begin
      write_word(8'(i), 4'(i + 8));
      wait_done(n);
    end
    check("overrun", ovr, 1'b1);
    for (int i = 0; i < 4; i++) read_word(8'h3C, 4'(i + 8));
    check("queue drained", rx_full, 1'b0);
    overrun_clear_i = 1'b1;
    tick(1);
    overrun_clear_i = 1'b0;
    tick(1);
    check("overrun clear", ovr, 1'b0);
    $display("test overrun done");
    enable_i = 1'b0;
    write_word(8'hC3, 4'hE);
    tick(4);
    check("no start", cs_n, 4'hF);
    check("held word", {empty, dma, done}, 3'b000);
    enable_i = 1'b1;
    wait_done(n);
    check("held sent", got, 8'hC3);
    read_word(8'h3C, 4'hE);
    $display("test enable done");
    dly = 8'h01;
    write_word(8'h5A, 4'h7);
    n = 0;
    while (rx_full !== 1'b1 && n < 100) begin tick(1); n++; end
    wait_done(n);
    check("delay wait", 16'(n >= DLY_UNIT_CYCLES), 16'h0001);
    read_word(8'h3C, 4'h7);
    $display("test delay done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: test/spi_slave_model.sv */
// behavioural serial slave that answers a fixed reply word
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
  input  wire logic       sclk_i,
  input  wire logic [3:0] cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic      [7:0] got_o
);
  logic       sel;
  logic [7:0] sh;
  int         cnt;
  assign sel = (cs_n_i != 4'hF);
  initial begin
    miso_o = 1'b0;
    got_o = 8'h00;
    sh = 8'h00;
    cnt = 0;
  end
  always @(posedge sel) begin
    sh = reply_i;
    cnt = 0;
    miso_o = reply_i[7];
  end
  // released line shows inverse of last bit
  always @(negedge sel) miso_o = ~miso_o;
  always @(posedge sclk_i) if (sel) begin
    got_o = {got_o[6:0], mosi_i};
    cnt = cnt + 1;
  end
  // msb first; reload for a back-to-back word
  always @(negedge sclk_i) if (sel) begin
    if (cnt == 8) begin
      sh = reply_i;
      cnt = 0;
    end else begin
      sh = {sh[6:0], 1'b0};
    end
    miso_o = sh[7];
  end
endmodule
`default_nettype wire
